// *** rtl/mmc_pkg.sv ***
// Purpose: shared constants and types for the motion module command interpreter
// Assumes: nine-byte frames, one motor, byte-wide serial link on mclk
// Notes:   status codes other than ok and event are local picks
package mmc_pkg;
	// ---------------------------------------------------------------
	// frame layout
	// ---------------------------------------------------------------
	localparam int          FRAME_LEN = 9;
	localparam logic [31:0] KEY_VALUE = 32'h0000_04D2;
	localparam logic [7:0]  MASK_ONE  = 8'h01;

	typedef struct packed {
		logic [7:0]  adr;
		logic [7:0]  op;
		logic [7:0]  typ;
		logic [7:0]  bank;
		logic [31:0] value;
	} mmc_frm_t;

	typedef struct packed {
		logic       raw;
		logic [7:0] ck_raw;
		mmc_frm_t   f;
	} mmc_rsp_t;

	// ---------------------------------------------------------------
	// reply status codes
	// ---------------------------------------------------------------
	localparam logic [7:0] ST_OK      = 8'h64;
	localparam logic [7:0] ST_EVENT   = 8'h80;
	localparam logic [7:0] ST_BAD_CK  = 8'h01;
	localparam logic [7:0] ST_BAD_OP  = 8'h02;
	localparam logic [7:0] ST_BAD_VAL = 8'h04;

	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_UF_LO   = 8'h40;
	localparam logic [7:0] OP_UF_HI   = 8'h47;
	localparam logic [7:0] OP_STOP    = 8'h80;
	localparam logic [7:0] OP_RUN     = 8'h81;
	localparam logic [7:0] OP_STEP    = 8'h82;
	localparam logic [7:0] OP_RESET   = 8'h83;
	localparam logic [7:0] OP_DL_ON   = 8'h84;
	localparam logic [7:0] OP_DL_OFF  = 8'h85;
	localparam logic [7:0] OP_RDMEM   = 8'h86;
	localparam logic [7:0] OP_STATUS  = 8'h87;
	localparam logic [7:0] OP_FWVER   = 8'h88;
	localparam logic [7:0] OP_FACTORY = 8'h89;
	localparam logic [7:0] OP_POSREQ  = 8'h8A;
	localparam logic [7:0] OP_SWRST   = 8'hFF;

	// ---------------------------------------------------------------
	// register map and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  RG_STATE = 8'h00;
	localparam logic [7:0]  RG_UFVAL = 8'h04;
	localparam logic [7:0]  RG_PC    = 8'h08;
	localparam logic [7:0]  RG_ACCU  = 8'h0C;
	localparam logic [7:0]  RG_INDEX = 8'h10;
	localparam logic [7:0]  RG_FLAGS = 8'h14;
	localparam logic [31:0] UFVAL_RST = 32'h0000_0000;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam logic [3:0] PR_SETTLE = 4'h2;

	typedef enum logic [1:0] {
		MMC_STOP,
		MMC_RUN,
		MMC_STEP
	} mmc_app_t;
endpackage

// *** rtl/mmc_rx_frame.sv ***
// Purpose: gather nine received bytes into one command frame
// Assumes: bytes arrive on mclk with a valid/ready handshake
// Notes:   frame held until taken; receive stalls meanwhile
module mmc_rx_frame (
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic [7:0]       rx_data,
	input  wire logic             rx_valid,
	output logic                  rx_ready,
	output logic                  frm_valid,
	output mmc_pkg::mmc_frm_t     frm,
	output logic                  frm_ck_ok,
	input  wire logic             frm_ready
);
	logic [3:0] cnt;
	logic [7:0] sum;

	assign rx_ready = !frm_valid;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt       <= 4'h0;
			sum       <= 8'h00;
			frm       <= '0;
			frm_valid <= 1'b0;
			frm_ck_ok <= 1'b0;
		end else begin
			if (frm_valid && frm_ready)
				frm_valid <= 1'b0;
			if (rx_valid && rx_ready) begin
				if (cnt == 4'(mmc_pkg::FRAME_LEN - 1)) begin
					// last byte is the sum of the eight before it
					frm_ck_ok <= (rx_data == sum);
					frm_valid <= 1'b1;
					cnt       <= 4'h0;
					sum       <= 8'h00;
				end else begin
					frm <= {frm[55:0], rx_data};
					sum <= sum + rx_data;
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule

// *** rtl/mmc_tx_frame.sv ***
// Purpose: send one reply frame as nine bytes
// Assumes: consumer may stall through tx_ready
// Notes:   raw replies carry their own ninth byte
module mmc_tx_frame (
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic             rsp_valid,
	input  mmc_pkg::mmc_rsp_t     rsp,
	output logic                  rsp_ready,
	output logic [7:0]            tx_data,
	output logic                  tx_valid,
	input  wire logic             tx_ready
);
	logic [71:0] sh;
	logic [3:0]  left;
	logic [7:0]  sum;

	assign rsp_ready = (left == 4'h0);

	always_comb begin
		sum = 8'h00;
		for (int i = 0; i < 8; i++)
			sum = sum + rsp.f[i*8 +: 8];
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sh       <= '0;
			left     <= 4'h0;
			tx_data  <= 8'h00;
			tx_valid <= 1'b0;
		end else if (rsp_valid && rsp_ready) begin
			// checksum over the eight header and value bytes
			sh       <= {rsp.f[55:0], (rsp.raw ? rsp.ck_raw : sum), 8'h00};
			tx_data  <= rsp.f[63:56];
			tx_valid <= 1'b1;
			left     <= 4'(mmc_pkg::FRAME_LEN);
		end else if (tx_valid && tx_ready) begin
			tx_data  <= sh[71:64];
			sh       <= {sh[63:0], 8'h00};
			left     <= left - 4'h1;
			tx_valid <= (left != 4'h1);
		end
	end
endmodule

// *** rtl/mmc_ctrl.sv ***
// Purpose: command interpreter for a single-axis motion module
// Assumes: byte link and motion logic share mclk; registers on a plain port
// Notes:   reply held until the serializer takes it; new frames stall meanwhile
module mmc_ctrl #(
	parameter int          MEM_DEPTH = 256,
	parameter logic [7:0]  MOD_ADDR  = 8'h01,
	parameter logic [7:0]  HOST_ADDR = 8'h02,
	parameter logic [7:0]  MOVE_OP   = 8'h04,
	// version values are arbitrary
	parameter logic [31:0] FW_BIN    = 32'h0001_0000,
	parameter logic [63:0] FW_STR    = 64'h4D4D_4331_5630_3130
) (
	input  wire logic              mclk,
	input  wire logic              arst_n,
	input  wire logic [7:0]        rx_data,
	input  wire logic              rx_valid,
	output logic                   rx_ready,
	output logic [7:0]             tx_data,
	output logic                   tx_valid,
	input  wire logic              tx_ready,
	output logic                   exec_valid,
	output mmc_pkg::mmc_frm_t      exec_cmd,
	output logic                   prog_valid,
	output mmc_pkg::mmc_frm_t      prog_cmd,
	input  wire logic              prog_ready,
	input  wire logic              pos_reached,
	input  wire logic              wait_active,
	output logic                   factory_restore,
	output logic                   soft_reset_req,
	output logic                   app_running,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata
);
	localparam int AW = $clog2(MEM_DEPTH);

	// ---------------------------------------------------------------
	// frame in, reply out
	// ---------------------------------------------------------------
	logic              frm_valid;
	logic              frm_ck_ok;
	mmc_pkg::mmc_frm_t frm;
	logic              rsp_valid;
	logic              rsp_ready;
	mmc_pkg::mmc_rsp_t rsp;

	mmc_rx_frame u_rx (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.rx_data   (rx_data),
		.rx_valid  (rx_valid),
		.rx_ready  (rx_ready),
		.frm_valid (frm_valid),
		.frm       (frm),
		.frm_ck_ok (frm_ck_ok),
		.frm_ready (!rsp_valid)
	);

	mmc_tx_frame u_tx (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.rsp_valid (rsp_valid),
		.rsp       (rsp),
		.rsp_ready (rsp_ready),
		.tx_data   (tx_data),
		.tx_valid  (tx_valid),
		.tx_ready  (tx_ready)
	);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	mmc_pkg::mmc_app_t app;
	mmc_pkg::mmc_frm_t mem [MEM_DEPTH];
	logic              dl_mode;
	logic [AW-1:0]     dl_ptr;
	logic [AW-1:0]     pc;
	logic [7:0]        sp;
	logic [31:0]       accu;
	logic [31:0]       index;
	logic [31:0]       flags;
	logic [31:0]       uf_value;
	logic              pr_arm;
	logic              pr_every;
	logic [7:0]        pr_mask;
	logic              pr_pend;
	logic [3:0]        pr_settle;
	logic              pr_due;
	logic              swrst_pend;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic take;
	logic good;
	logic is_ctl;
	logic is_uf;
	logic is_pr;
	logic key_ok;
	logic store;
	logic is_move;

	assign take    = frm_valid && !rsp_valid;
	assign good    = take && frm_ck_ok && (frm.adr == MOD_ADDR);
	assign is_ctl  = (frm.op >= mmc_pkg::OP_STOP && frm.op <= mmc_pkg::OP_FACTORY) ||
	                 (frm.op == mmc_pkg::OP_SWRST);
	assign is_uf   = (frm.op >= mmc_pkg::OP_UF_LO) && (frm.op <= mmc_pkg::OP_UF_HI);
	assign is_pr   = (frm.op == mmc_pkg::OP_POSREQ);
	assign key_ok  = (frm.value == mmc_pkg::KEY_VALUE);
	// control and position request bypass download mode
	assign store   = good && dl_mode && !is_ctl && !is_pr;
	assign is_move = good && !store && (frm.op == MOVE_OP);

	// ---------------------------------------------------------------
	// reply for the frame being taken
	// ---------------------------------------------------------------
	mmc_pkg::mmc_rsp_t next_rsp;
	logic              next_send;
	mmc_pkg::mmc_frm_t rd_word;

	assign rd_word = mem[frm.value[AW-1:0]];

	always_comb begin
		next_rsp         = '0;
		next_rsp.f.adr   = HOST_ADDR;
		next_rsp.f.op    = MOD_ADDR;
		next_rsp.f.typ   = mmc_pkg::ST_OK;
		next_rsp.f.bank  = frm.op;
		next_rsp.f.value = 32'h0000_0000;
		next_send        = 1'b1;
		if (!frm_ck_ok) begin
			next_rsp.f.typ = mmc_pkg::ST_BAD_CK;
		end else if (store) begin
			next_rsp.f.value = frm.value;
		end else if (is_uf) begin
			next_rsp.f.value = uf_value;
		end else begin
			case (frm.op)
				mmc_pkg::OP_POSREQ: begin
					next_rsp.f.value = {24'h00_0000, frm.value[7:0]};
				end
				mmc_pkg::OP_STOP, mmc_pkg::OP_RUN, mmc_pkg::OP_STEP,
				mmc_pkg::OP_RESET, mmc_pkg::OP_DL_ON, mmc_pkg::OP_DL_OFF: begin
					next_rsp.f.value = 32'h0000_0000;
				end
				mmc_pkg::OP_RDMEM: begin
					// special reply: the stored frame, with HOST_ADDR as its address byte
					next_rsp.f = rd_word;
					next_rsp.f.adr = HOST_ADDR;
				end
				mmc_pkg::OP_STATUS: begin
					case (frm.typ)
						8'h00: next_rsp.f.value = {6'h00, app, 7'h00, wait_active, 16'(dl_ptr)};
						8'h01: next_rsp.f.value = {6'h00, app, 7'h00, wait_active, 16'(pc)};
						8'h02: next_rsp.f.value = accu;
						8'h03: next_rsp.f.value = index;
						default: next_rsp.f.typ = mmc_pkg::ST_BAD_VAL;
					endcase
				end
				mmc_pkg::OP_FWVER: begin
					if (frm.typ == 8'h00) begin
						// string reply: eight characters, no checksum slot
						next_rsp.raw    = 1'b1;
						next_rsp.f.op   = FW_STR[63:56];
						next_rsp.f.typ  = FW_STR[55:48];
						next_rsp.f.bank = FW_STR[47:40];
						next_rsp.f.value = FW_STR[39:8];
						next_rsp.ck_raw = FW_STR[7:0];
					end else begin
						next_rsp.f.value = FW_BIN;
					end
				end
				mmc_pkg::OP_FACTORY: begin
					next_send = !key_ok;
					next_rsp.f.typ = mmc_pkg::ST_BAD_VAL;
				end
				mmc_pkg::OP_SWRST: begin
					if (!key_ok)
						next_rsp.f.typ = mmc_pkg::ST_BAD_VAL;
				end
				default: begin
					if (frm.op >= mmc_pkg::OP_STOP)
						next_rsp.f.typ = mmc_pkg::ST_BAD_OP;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// reply register: frame replies first, event reply in idle slots
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_valid <= 1'b0;
			rsp       <= '0;
		end else if (rsp_valid) begin
			if (rsp_ready)
				rsp_valid <= 1'b0;
		end else if (take && frm.adr == MOD_ADDR) begin
			rsp_valid <= next_send;
			rsp       <= next_rsp;
		end else if (pr_due && !frm_valid) begin
			rsp_valid        <= 1'b1;
			rsp              <= '0;
			rsp.f.adr        <= HOST_ADDR;
			rsp.f.op         <= MOD_ADDR;
			rsp.f.typ        <= mmc_pkg::ST_EVENT;
			rsp.f.bank       <= mmc_pkg::OP_POSREQ;
			rsp.f.value      <= {24'h00_0000, pr_mask};
		end
	end

	// ---------------------------------------------------------------
	// position reached tracking
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pr_arm    <= 1'b0;
			pr_every  <= 1'b0;
			pr_mask   <= mmc_pkg::MASK_ONE;
			pr_pend   <= 1'b0;
			pr_settle <= 4'h0;
			pr_due    <= 1'b0;
		end else begin
			// the set below wins over this clear, so a back-to-back event is kept
			if (pr_due && !rsp_valid && !take && !frm_valid)
				pr_due <= 1'b0;
			if (good && is_pr && !store) begin
				pr_arm   <= 1'b1;
				pr_every <= frm.typ[0];
				pr_mask  <= frm.value[7:0];
			end else if (is_move && pr_arm) begin
				// settle lets the motion logic drop its reached flag first
				pr_pend   <= 1'b1;
				pr_settle <= mmc_pkg::PR_SETTLE;
				if (!pr_every)
					pr_arm <= 1'b0;
			end else if (pr_pend && pr_settle != 4'h0) begin
				pr_settle <= pr_settle - 4'h1;
			end else if (pr_pend && pos_reached) begin
				pr_pend <= 1'b0;
				pr_due  <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// application control
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			app <= mmc_pkg::MMC_STOP;
			pc  <= '0;
			sp  <= 8'h00;
		end else if (good && frm_ck_ok && !store) begin
			case (frm.op)
				mmc_pkg::OP_STOP: app <= mmc_pkg::MMC_STOP;
				mmc_pkg::OP_RUN: begin
					app <= mmc_pkg::MMC_RUN;
					if (frm.typ == 8'h01)
						pc <= frm.value[AW-1:0];
				end
				mmc_pkg::OP_STEP: app <= mmc_pkg::MMC_STEP;
				mmc_pkg::OP_RESET: begin
					app <= mmc_pkg::MMC_STOP;
					pc  <= '0;
					sp  <= 8'h00;
				end
				default: app <= app;
			endcase
		end else if (app != mmc_pkg::MMC_STOP && (!prog_valid || prog_ready)) begin
			pc <= pc + 1'b1;
			if (app == mmc_pkg::MMC_STEP)
				app <= mmc_pkg::MMC_STOP;
		end
	end

	assign app_running = (app != mmc_pkg::MMC_STOP);

	// stored command handed to the executor, one at a time
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			prog_valid <= 1'b0;
			prog_cmd   <= '0;
		// a direct frame holds pc, so no word may load here either or it repeats
		end else if (app != mmc_pkg::MMC_STOP && !(good && !store) &&
		             (!prog_valid || prog_ready)) begin
			prog_valid <= 1'b1;
			prog_cmd   <= mem[pc];
		end else if (prog_ready) begin
			prog_valid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// download and program memory
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dl_mode <= 1'b0;
			dl_ptr  <= '0;
		end else if (good && frm_ck_ok) begin
			if (store)
				dl_ptr <= dl_ptr + 1'b1;
			else if (frm.op == mmc_pkg::OP_DL_ON) begin
				dl_mode <= 1'b1;
				dl_ptr  <= frm.value[AW-1:0];
			end else if (frm.op == mmc_pkg::OP_DL_OFF)
				dl_mode <= 1'b0;
		end
	end

	// memory holds no reset: contents are data, not control
	always_ff @(posedge mclk) begin
		if (store && frm_ck_ok)
			mem[dl_ptr] <= frm;
	end

	// ---------------------------------------------------------------
	// direct commands to the motion logic, one-cycle strobes
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			exec_valid      <= 1'b0;
			exec_cmd        <= '0;
			factory_restore <= 1'b0;
			soft_reset_req  <= 1'b0;
			swrst_pend      <= 1'b0;
		end else begin
			exec_valid      <= good && frm_ck_ok && !store && !is_ctl && !is_pr && !is_uf;
			factory_restore <= good && frm_ck_ok && frm.op == mmc_pkg::OP_FACTORY && key_ok;
			if (good && frm_ck_ok && !store)
				exec_cmd <= frm;
			// restart only after the serializer took the reply, so it may still get out
			soft_reset_req <= swrst_pend && rsp_valid && rsp_ready;
			if (good && frm_ck_ok && frm.op == mmc_pkg::OP_SWRST && key_ok)
				swrst_pend <= 1'b1;
			else if (rsp_valid && rsp_ready)
				swrst_pend <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			uf_value <= mmc_pkg::UFVAL_RST;
			accu     <= 32'h0000_0000;
			index    <= 32'h0000_0000;
			flags    <= 32'h0000_0000;
		end else if (good && frm_ck_ok && !store && frm.op == mmc_pkg::OP_RESET) begin
			accu  <= 32'h0000_0000;
			index <= 32'h0000_0000;
			flags <= 32'h0000_0000;
		end else if (reg_wr) begin
			case (reg_addr)
				mmc_pkg::RG_UFVAL: uf_value <= reg_wdata;
				mmc_pkg::RG_ACCU:  accu     <= reg_wdata;
				mmc_pkg::RG_INDEX: index    <= reg_wdata;
				mmc_pkg::RG_FLAGS: flags    <= reg_wdata;
				default:           uf_value <= uf_value;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				mmc_pkg::RG_STATE: reg_rdata <= {sp, 16'(dl_ptr), 1'b0, pr_due, pr_pend, pr_arm,
				                                 dl_mode, 1'b0, app};
				mmc_pkg::RG_UFVAL: reg_rdata <= uf_value;
				mmc_pkg::RG_PC:    reg_rdata <= 32'(pc);
				mmc_pkg::RG_ACCU:  reg_rdata <= accu;
				mmc_pkg::RG_INDEX: reg_rdata <= index;
				mmc_pkg::RG_FLAGS: reg_rdata <= flags;
				default:           reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// *** verif/mmc_ctrl_monitor.sv ***
// Purpose: port checks on the command interpreter
// Assumes: one clock mclk, reset arst_n low
// Notes:   frame contents are judged by the bench
module mmc_ctrl_monitor (
	input  wire logic         mclk,
	input  wire logic         arst_n,
	input  wire logic [7:0]   tx_data,
	input  wire logic         tx_valid,
	input  wire logic         tx_ready,
	input  wire logic         exec_valid,
	input  mmc_pkg::mmc_frm_t exec_cmd,
	input  wire logic         prog_valid,
	input  mmc_pkg::mmc_frm_t prog_cmd,
	input  wire logic         prog_ready,
	input  wire logic         factory_restore,
	input  wire logic         soft_reset_req,
	input  wire logic         app_running,
	input  wire logic         reg_rd,
	input  wire logic [31:0]  reg_rdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic ex_ctl;
	logic pg_ctl;
	// position request counts as control: never executed or stored
	assign ex_ctl = (exec_cmd.op >= 8'h80 && exec_cmd.op <= 8'h8A) || exec_cmd.op == 8'hFF;
	assign pg_ctl = (prog_cmd.op >= 8'h80 && prog_cmd.op <= 8'h8A) || prog_cmd.op == 8'hFF;
	sequence s_tx_stall;
		tx_valid && !tx_ready;
	endsequence
	sequence s_pg_stall;
		prog_valid && !prog_ready;
	endsequence
	chk_tx_hold: assert property (s_tx_stall |=> tx_valid && $stable(tx_data))
		else $error("reply byte moved while stalled");
	chk_rdata_zero: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	chk_exec_direct: assert property (exec_valid |-> !ex_ctl)
		else $error("control opcode passed to motion");
	chk_prog_direct: assert property (prog_valid |-> !pg_ctl)
		else $error("control opcode in program");
	chk_prog_hold: assert property (s_pg_stall |=> prog_valid && $stable(prog_cmd))
		else $error("program word dropped");
	chk_prog_start: assert property ($rose(prog_valid) |-> $past(app_running))
		else $error("program word while stopped");
	chk_fac_pulse: assert property (factory_restore |=> !factory_restore)
		else $error("restore pulse too long");
	chk_rst_pulse: assert property (soft_reset_req |=> !soft_reset_req)
		else $error("restart pulse too long");
endmodule

bind mmc_ctrl mmc_ctrl_monitor i_mon (.mclk, .arst_n, .tx_data, .tx_valid, .tx_ready, .exec_valid, .exec_cmd,
	.prog_valid, .prog_cmd, .prog_ready, .factory_restore, .soft_reset_req, .app_running, .reg_rd, .reg_rdata);

// *** verif/mmc_host_model.sv ***
// Purpose: host end of the byte link
// Assumes: byte handshakes on mclk
// Notes:   slow mode takes a reply byte only every other cycle
module mmc_host_model (
	input  wire logic       mclk,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic       slow
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] q[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end
	always @(posedge mclk) begin
		if (tx_valid && tx_ready)
			q.push_back(tx_data);
		tx_ready <= !slow || !tx_ready;
	end
	// nine bytes, last is the byte sum
	task automatic send(input logic [63:0] f);
		logic [7:0] ck;
		ck = 8'h00;
		for (int i = 0; i < 9; i++) begin
			rx_data <= (i < 8) ? f[63-8*i -: 8] : ck;
			rx_valid <= 1'b1;
			if (i < 8)
				ck = ck + f[63-8*i -: 8];
			@(posedge mclk iff rx_ready);
		end
		rx_valid <= 1'b0;
		// released line must not keep the last byte
		rx_data <= ~rx_data;
	endtask
endmodule

// *** verif/motion_module_control_commands_tb_top.sv ***
// Purpose: self-checking bench for the command interpreter
// Assumes: default MOD_ADDR, HOST_ADDR and version values
// Notes:   reply values of motion commands are not judged
module motion_module_control_commands_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MOVE = 8'h04;
	logic mclk, arst_n, rx_valid, rx_ready, tx_valid, tx_ready, exec_valid, prog_valid, prog_ready;
	logic pos_reached, wait_active, factory_restore, soft_reset_req, app_running, reg_wr, reg_rd, slow;
	logic [7:0] rx_data, tx_data, reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	mmc_pkg::mmc_frm_t exec_cmd, prog_cmd;
	logic [63:0] g;
	int n_fail, comparisons, n_ex, n_fr, n_sr, cyc;
	mmc_ctrl #(.MOVE_OP(MOVE)) i_dut (.mclk, .arst_n, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid,
		.tx_ready, .exec_valid, .exec_cmd, .prog_valid, .prog_cmd, .prog_ready, .pos_reached, .wait_active,
		.factory_restore, .soft_reset_req, .app_running, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	mmc_host_model i_host (.mclk, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready, .slow);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		n_ex += (exec_valid === 1'b1);
		n_fr += (factory_restore === 1'b1);
		n_sr += (soft_reset_req === 1'b1);
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [63:0] e, input logic [63:0] s);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		check("reg", {32'h0, e}, {32'h0, reg_rdata});
		@(posedge mclk);
	endtask
	// negedge sampling keeps clear of the model's pushes
	task automatic cmd(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] v);
		logic [7:0] ck;
		i_host.send({8'h01, op, ty, 8'h00, v});
		ck = 8'h00;
		while (i_host.q.size() < 9) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			g = {g[55:0], i_host.q[0]};
			ck = ck + i_host.q.pop_front();
		end
		check("checksum", {56'h0, ck}, {56'h0, i_host.q.pop_front()});
		@(posedge mclk);
	endtask
	task automatic quiet(input int nf);
		repeat (40) @(posedge mclk);
		check("extra reply", 0, i_host.q.size());
		check("restore pulses", nf, n_fr);
	endtask
	task automatic move(input logic ev);
		int ne;
		ne = n_ex;
		cmd(MOVE, 8'h00, 32'h0000_0100);
		check("move status", mmc_pkg::ST_OK, g[47:40]);
		check("exec pulses", ne + 1, n_ex);
		if (ev) begin
			while (i_host.q.size() < 9) @(negedge mclk);
			cmd(8'h00, 8'h00, 32'h0); // second frame also goes to this module: cmd always sends address 01, and here opcode 00
		end
	endtask
	task automatic t_user();
		slow <= 1'b1;
		reg_write(mmc_pkg::RG_UFVAL, 32'hA5C3_0F01);
		reg_read(mmc_pkg::RG_UFVAL, 32'hA5C3_0F01);
		reg_read(8'hFC, 32'h0);
		for (int op = 8'h40; op <= 8'h47; op++) begin
			cmd(op[7:0], 8'h07, 32'h0);
			check("user reply", {16'h0201, mmc_pkg::ST_OK, op[7:0], 32'hA5C3_0F01}, g);
		end
		slow <= 1'b0;
	endtask
	task automatic t_event();
		pos_reached <= 1'b1;
		for (int ty = 0; ty < 2; ty++) begin
			cmd(mmc_pkg::OP_POSREQ, ty[7:0], 32'h1);
			check("request reply", {16'h0201, mmc_pkg::ST_OK, mmc_pkg::OP_POSREQ, 32'h1}, g);
			for (int k = 0; k < 2; k++) begin
				cmd(MOVE, 8'h00, 32'h0000_0100);
				check("move status", {56'h0, mmc_pkg::ST_OK}, {56'h0, g[47:40]});
				if (ty == 1 || k == 0) begin
					i_host.q.push_front(8'h00);
					void'(i_host.q.pop_front());
					while (i_host.q.size() < 9) @(negedge mclk);
					g = {i_host.q[0], i_host.q[1], i_host.q[2], i_host.q[3], i_host.q[4], i_host.q[5],
						i_host.q[6], i_host.q[7]};
					check("event checksum", 8'h0E, i_host.q[8]);
					i_host.q.delete();
					check("event reply", {16'h0201, mmc_pkg::ST_EVENT, mmc_pkg::OP_POSREQ, 32'h1}, g);
				end else
					quiet(0);
			end
		end
	endtask
	task automatic t_prog();
		int ne;
		cmd(mmc_pkg::OP_DL_ON, 8'h00, 32'h0);
		ne = n_ex;
		cmd(8'h05, 8'h02, 32'h77);
		check("stored reply", {16'h0201, mmc_pkg::ST_OK, 8'h05, 32'h77}, g);
		check("exec pulses", ne, n_ex);
		cmd(8'h05, 8'h00, 32'h66);
		cmd(mmc_pkg::OP_DL_OFF, 8'h00, 32'h0);
		cmd(mmc_pkg::OP_RDMEM, 8'h00, 32'h0);
		check("memory word", {32'h0205_0200, 32'h77}, g);
		cmd(8'h05, 8'h02, 32'h77);
		check("exec pulses", ne + 1, n_ex);
		prog_ready <= 1'b0;
		cmd(mmc_pkg::OP_RUN, 8'h01, 32'h0);
		check("program word", {8'h05, 32'h77}, {prog_cmd.op, prog_cmd.value});
		check("running", 1, app_running);
		// stalled executor keeps unwritten words from being fetched
		cmd(mmc_pkg::OP_STOP, 8'h00, 32'h0);
		check("stopped", 0, app_running);
		prog_ready <= 1'b1;
		@(posedge mclk);
		prog_ready <= 1'b0;
		cmd(mmc_pkg::OP_STEP, 8'h00, 32'h0);
		check("step state", {2'b01, 32'h66}, {app_running, prog_valid, prog_cmd.value});
		prog_ready <= 1'b1;
		reg_write(mmc_pkg::RG_ACCU, 32'h55);
		cmd(mmc_pkg::OP_RESET, 8'h00, 32'h0);
		reg_read(mmc_pkg::RG_ACCU, 32'h0);
		reg_read(mmc_pkg::RG_PC, 32'h0);
		wait_active <= 1'b1;
		cmd(mmc_pkg::OP_STATUS, 8'h01, 32'h0);
		check("status pc", 32'h0001_0000, g[31:0]);
		cmd(mmc_pkg::OP_STATUS, 8'h00, 32'h0);
		check("status pointer", 32'h0001_0002, g[31:0]);
		reg_write(mmc_pkg::RG_ACCU, 32'h1234_5678);
		cmd(mmc_pkg::OP_STATUS, 8'h02, 32'h0);
		check("status accu", 32'h1234_5678, g[31:0]);
		cmd(mmc_pkg::OP_FWVER, 8'h01, 32'h0);
		check("version", 32'h0001_0000, g[31:0]);
	endtask
	task automatic t_keys();
		cmd(mmc_pkg::OP_FACTORY, 8'h00, 32'h1);
		check("bad key", mmc_pkg::ST_BAD_VAL, g[47:40]);
		i_host.send({16'h0189, 16'h0, mmc_pkg::KEY_VALUE});
		quiet(1);
		cmd(mmc_pkg::OP_SWRST, 8'h00, 32'h1);
		check("bad restart key", mmc_pkg::ST_BAD_VAL, g[47:40]);
		cmd(mmc_pkg::OP_SWRST, 8'h00, mmc_pkg::KEY_VALUE);
		repeat (4) @(posedge mclk);
		check("restart pulses", 1, n_sr);
	endtask
	initial begin
		{arst_n, prog_ready, pos_reached, wait_active, reg_wr, reg_rd, slow} = '0;
		{reg_addr, reg_wdata, g} = '0;
		{n_fail, comparisons, n_ex, n_fr, n_sr, cyc} = '0;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		t_user();
		t_event();
		t_prog();
		t_keys();
		print_verdict();
	end
endmodule
